// ==== hdl/sbuf_defines.svh ====
// Constants of the smoothing buffer.
// Assumes inclusion by bare name.
`ifndef SBUF_DEFINES_SVH
`define SBUF_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define SBUF_OFS_CTRL       12'h000
`define SBUF_OFS_FILL       12'h004
`define SBUF_OFS_STATUS     12'h008
`define SBUF_OFS_INT_STAT   12'h00c
`define SBUF_OFS_INT_MASK   12'h010

// ==========================================================================
// Control register fields
`define SBUF_CTRL_RATE_CONV 0
`define SBUF_CTRL_BALANCED  1
`define SBUF_CTRL_RESET     2'h0
`define SBUF_FILL_RESET     10'h000

// ==========================================================================
// Status register fields
`define SBUF_ST_WR_LSB      0
`define SBUF_ST_RD_LSB      4
`define SBUF_ST_CARD_ERR    8
`define SBUF_ST_ACTIVE      9
`define SBUF_ST_LEAD        10
`define SBUF_ST_LAG         11
`define SBUF_ST_WORD_LSB    16

// ==========================================================================
// Interrupt status and mask fields
`define SBUF_INT_CARD_ERR   0
`define SBUF_INT_ACT_LOSS   1
`define SBUF_INT_MISMATCH   2
`define SBUF_INT_RESET      3'h0

// ==========================================================================
// Store geometry and frame positions
`define SBUF_ADDR_W         4
`define SBUF_WR_ADDR_RESET  4'h8
`define SBUF_RD_ADDR_RESET  4'h0
`define SBUF_WORD_W         10
`define SBUF_INHIBIT_STAGES 5

// ==========================================================================
// Timing: end-of-scan activity window in clocks
`define SBUF_ACT_CYCLES     2000

`endif

// ==== hdl/sbuf_pkg.sv ====
// Types shared by the smoothing buffer modules.
// Assumes the constants header is on the include path.
`include "sbuf_defines.svh"

package sbuf_pkg;
    // Diagnostic compare sequence, one-hot
    typedef enum logic [2:0] {
        SBUF_DG_IDLE  = 3'b001,
        SBUF_DG_ARMED = 3'b010,
        SBUF_DG_CMP   = 3'b100
    } sbuf_diag_t;
endpackage

// ==== hdl/sbuf_rate_conv.sv ====
// Coarse rate conversion: word counter, word-29 inhibit, reversed compare.
// Assumes one-cycle pulses already synchronised to the system clock.
`timescale 1ns/1ps
`include "sbuf_defines.svh"

module sbuf_rate_conv
    import sbuf_pkg::*;
#(
    parameter int WORD_W = `SBUF_WORD_W
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              enable,      // Rate conversion selected
    input  wire logic              eos,         // End-of-scan pulse
    input  wire logic              w24,         // Word 24 strobe level
    input  wire logic              mf31,        // Minor frame 31 level
    input  wire logic [WORD_W-1:0] fill_count,  // Fill-bit count B
    input  wire logic              wclk_in,     // Gated clock pulse in
    output logic                   wclk_out,    // Thinned gated clock pulse
    output logic [WORD_W-1:0]      word_count,  // Current word count
    output logic                   hold         // Word 29 inhibit
);

    // ======================================================================
    // Declarations
    logic [`SBUF_INHIBIT_STAGES-1:0] inh_sr_r;  // Word 24 marker delay line
    logic [WORD_W-1:0]               word_r;    // Word counter
    logic                            del_pend_r; // One deletion owed this word
    logic                            below;     // Reversed count below fill
    logic                            eat;       // Gated clock removed now

    // Bit reversal of the word count
    function automatic logic [WORD_W-1:0] reverse(input logic [WORD_W-1:0] v);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < WORD_W; i++) begin
            r[i] = v[WORD_W-1-i];
        end
        return r;
    endfunction

    // ======================================================================
    // Word-29 inhibit shift register
    // (R10) word 24 marker
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            inh_sr_r <= '0;
        end else if (eos) begin
            inh_sr_r <= {inh_sr_r[`SBUF_INHIBIT_STAGES-2:0], w24};
        end
    end
    assign hold = inh_sr_r[`SBUF_INHIBIT_STAGES-1];

    // ======================================================================
    // Word counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            word_r <= '0;
        end else if (eos) begin
            // (R9) preset at frame end
            if (w24 && mf31) begin
                word_r <= '0;
            // (R10) hold during word 29
            end else if (!hold) begin
                // (R9) advance per scan
                word_r <= word_r + 1'b1;
            end
        end
    end
    assign word_count = word_r;

    // ======================================================================
    // Comparator and deletion
    // (R11) (R12) reversed A below B
    assign below = reverse(word_r) < fill_count;
    // (R8) (R10) thin only when allowed
    assign eat      = enable && !hold && del_pend_r && wclk_in;
    assign wclk_out = wclk_in && !eat;

    // One deletion armed per word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            del_pend_r <= 1'b0;
        end else if (eos) begin
            del_pend_r <= below;
        end else if (eat) begin
            del_pend_r <= 1'b0;
        end
    end

endmodule

// ==== hdl/sbuf_top.sv ====
// Channel smoothing buffer: elastic store, output stage, diagnostics, APB.
// Assumes link pins arrive asynchronous to CLK_SYS and run well below it.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "sbuf_defines.svh"

// Overview of operation
// (R1) Write counter steps per gated clock
// (R2) Read counter steps per read clock
// (R3) Output clock registers data, drives timing
// (R4) Balanced gives complements, unbalanced true only
// (R5) Scan activity loss inhibits data output
// (R6) Write and read kept eight apart
// (R7) Phase error steers oscillator gradually
// (R8) Thinning only in rate conversion mode
// (R9) Word counter per scan, preset frame end
// (R10) Word 29 inhibit holds counter, no deletion
// (R11) Inhibit gated clock while A below B
// (R12) Word count applied bit reversed
// (R13) Word24 bit0 captures address and data
// (R14) Address match arms compare next clock
// (R15) Latched bit versus output bit compared
// (R16) Any error input latches card error
// (R17) Card error cleared only by reset pin
// (R18) Self test forces card error
// (R19) Environment supplies tracking read clock
module sbuf_top
    import sbuf_pkg::*;
#(
    parameter int ACT_CYCLES = `SBUF_ACT_CYCLES
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    // Demultiplexer side
    input  wire logic        GATED_WRITE_CLOCK,
    input  wire logic        CHANNEL_DATA_IN,
    input  wire logic        END_OF_SCAN_PULSE,
    input  wire logic        WORD24_STROBE,
    input  wire logic        WORD24_BIT0_STROBE,
    input  wire logic        MINOR_FRAME31,
    // Recovered read clock
    input  wire logic        READ_CLOCK,
    output logic             PHASE_LEAD,
    output logic             PHASE_LAG,
    // Line side
    output logic             CHANNEL_DATA_OUT,
    output logic             CHANNEL_DATA_OUT_N,
    output logic             CHANNEL_TIMING_OUT,
    output logic             CHANNEL_TIMING_OUT_N,
    input  wire logic        DATA_DRIVER_ERR,
    input  wire logic        TIMING_DRIVER_ERR,
    // Front panel and overhead
    input  wire logic        ERROR_RESET,
    input  wire logic        SELF_TEST_FORCE,
    output logic             CARD_ERROR_STUFF_REQUEST_N
);

    // ======================================================================
    // Pin index map
    localparam int NPIN   = 11;
    localparam int P_GW   = 0;
    localparam int P_DIN  = 1;
    localparam int P_EOS  = 2;
    localparam int P_W24  = 3;
    localparam int P_W240 = 4;
    localparam int P_MF31 = 5;
    localparam int P_RCK  = 6;
    localparam int P_DERR = 7;
    localparam int P_TERR = 8;
    localparam int P_ERST = 9;
    localparam int P_ST   = 10;
    localparam int AW     = `SBUF_ADDR_W;
    localparam int WW     = `SBUF_WORD_W;
    localparam int ACT_W  = $clog2(ACT_CYCLES + 1);

    // ======================================================================
    // Declarations
    logic [NPIN-1:0] pin_raw;                   // Raw pin vector
    logic [NPIN-1:0] pin_s1_r;                  // Synchroniser stage one
    logic [NPIN-1:0] pin_s2_r;                  // Synchroniser stage two
    logic [NPIN-1:0] pin_s3_r;                  // Delayed copy for edges
    logic [NPIN-1:0] pin_rise;                  // Rising edges
    logic            gw_pulse;                  // Gated clock edge
    logic            gw_thin;                   // After rate conversion
    logic            rck_pulse;                 // Read clock edge
    logic            eos_pulse;                 // End-of-scan edge
    logic            store_r [2**AW];           // Elastic store
    logic [AW-1:0]   wr_addr_r;                 // Write address counter
    logic [AW-1:0]   rd_addr_r;                 // Read address counter
    logic            dout_r;                    // Data output buffer
    logic [ACT_W-1:0] act_cnt_r;                // Activity timer
    logic            active;                    // Scans are arriving
    logic            active_d_r;                // Previous activity state
    logic [AW-1:0]   cap_addr_r;                // Diagnostic address latch
    logic            cap_data_r;                // Diagnostic data latch
    sbuf_diag_t      diag_r;                    // Diagnostic sequence
    logic            mismatch;                  // Compare failure pulse
    logic            card_err_r;                // Latched card error
    logic            card_err_d_r;              // Previous card error
    logic            lead_r;                    // Read ahead of write
    logic            lag_r;                     // Read behind write
    logic [1:0]      ctrl_r;                    // Mode control
    logic [WW-1:0]   fill_r;                    // Fill-bit count
    logic [2:0]      int_stat_r;                // Sticky events
    logic [2:0]      int_mask_r;                // Event enables
    logic [2:0]      int_ev;                    // Event pulses
    logic [2:0]      int_clr;                   // Write-one clear bits
    logic [WW-1:0]   word_count;                // Rate converter count
    logic            rc_hold;                   // Word 29 inhibit
    logic            apb_wr;                    // Write access phase
    logic            apb_setup;                 // Setup phase
    logic [31:0]     rd_mux;                    // Read data selection
    logic            mapped;                    // Address decodes

    // ======================================================================
    // Input synchronisers
    assign pin_raw = {SELF_TEST_FORCE, ERROR_RESET, TIMING_DRIVER_ERR, DATA_DRIVER_ERR,
                      READ_CLOCK, MINOR_FRAME31, WORD24_BIT0_STROBE, WORD24_STROBE,
                      END_OF_SCAN_PULSE, CHANNEL_DATA_IN, GATED_WRITE_CLOCK};

    // Two flops then an edge copy
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    assign pin_rise  = pin_s2_r & ~pin_s3_r;
    assign gw_pulse  = pin_rise[P_GW];
    assign rck_pulse = pin_rise[P_RCK];
    assign eos_pulse = pin_rise[P_EOS];

    // ======================================================================
    // Coarse rate conversion
    sbuf_rate_conv #(
        .WORD_W     (WW)
    ) u_rate_conv (
        .clk        (CLK_SYS),
        .rst_b      (RST_B),
        .enable     (ctrl_r[`SBUF_CTRL_RATE_CONV]),
        .eos        (eos_pulse),
        .w24        (pin_s2_r[P_W24]),
        .mf31       (pin_s2_r[P_MF31]),
        .fill_count (fill_r),
        .wclk_in    (gw_pulse),
        .wclk_out   (gw_thin),
        .word_count (word_count),
        .hold       (rc_hold)
    );

    // ======================================================================
    // Write side of the elastic store
    // (R1) step per gated clock
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wr_addr_r <= `SBUF_WR_ADDR_RESET;
        end else if (gw_thin) begin
            wr_addr_r <= wr_addr_r + 1'b1;
        end
    end

    // Cleared at reset
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < 2**AW; i++) begin
                store_r[i] <= 1'b0;
            end
        end else if (gw_thin) begin
            store_r[wr_addr_r] <= pin_s2_r[P_DIN];
        end
    end

    // ======================================================================
    // Read side and output buffer
    // (R2) step per read clock
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rd_addr_r <= `SBUF_RD_ADDR_RESET;
        end else if (rck_pulse) begin
            rd_addr_r <= rd_addr_r + 1'b1;
        end
    end

    // (R3) register data on output clock
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            dout_r <= 1'b0;
        end else if (rck_pulse) begin
            dout_r <= store_r[rd_addr_r];
        end
    end

    // (R3) (R4) (R5) line outputs
    assign CHANNEL_DATA_OUT     = dout_r && active;
    assign CHANNEL_DATA_OUT_N   = ctrl_r[`SBUF_CTRL_BALANCED] && active && !dout_r;
    assign CHANNEL_TIMING_OUT   = pin_s2_r[P_RCK];
    assign CHANNEL_TIMING_OUT_N = ctrl_r[`SBUF_CTRL_BALANCED] && !pin_s2_r[P_RCK];

    // ======================================================================
    // Phase detector
    // (R6) (R7) read minus write address compared against eight
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            lead_r <= 1'b0;
            lag_r  <= 1'b0;
        end else begin
            lead_r <= (rd_addr_r - wr_addr_r) > AW'(8);
            lag_r  <= (rd_addr_r - wr_addr_r) < AW'(8);
        end
    end
    // (R19) oscillator outside slews on these
    assign PHASE_LEAD = lead_r;
    assign PHASE_LAG  = lag_r;

    // ======================================================================
    // End-of-scan activity timer
    // (R5) retriggered by each scan
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            act_cnt_r <= '0;
        end else if (eos_pulse) begin
            act_cnt_r <= ACT_W'(ACT_CYCLES);
        end else if (act_cnt_r != '0) begin
            act_cnt_r <= act_cnt_r - 1'b1;
        end
    end
    assign active = act_cnt_r != '0;

    // ======================================================================
    // Diagnostic capture and compare
    // (R13) latch address and bit
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cap_addr_r <= '0;
            cap_data_r <= 1'b0;
        end else if (diag_r == SBUF_DG_IDLE && pin_s2_r[P_W240] && gw_thin) begin
            cap_addr_r <= wr_addr_r;
            cap_data_r <= pin_s2_r[P_DIN];
        end
    end

    // Compare sequence
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            diag_r <= SBUF_DG_IDLE;
        end else begin
            unique case (diag_r)
                // Wait for the capture strobe
                SBUF_DG_IDLE: begin
                    if (pin_s2_r[P_W240] && gw_thin) begin
                        diag_r <= SBUF_DG_ARMED;
                    end
                end
                // (R14) match at an output clock, compare next clock
                SBUF_DG_ARMED: begin
                    if (rck_pulse && rd_addr_r == cap_addr_r) begin
                        diag_r <= SBUF_DG_CMP;
                    end
                end
                // Compare enable for one cycle
                SBUF_DG_CMP: begin
                    diag_r <= SBUF_DG_IDLE;
                end
            endcase
        end
    end

    // (R15) latched bit versus output
    assign mismatch = (diag_r == SBUF_DG_CMP) && (dout_r != cap_data_r);

    // ======================================================================
    // Composite card error latch
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            card_err_r <= 1'b0;
        // (R16) (R18) any error or self test
        end else if (mismatch || pin_s2_r[P_DERR] || pin_s2_r[P_TERR] || pin_s2_r[P_ST]) begin
            card_err_r <= 1'b1;
        // (R17) panel reset only
        end else if (pin_s2_r[P_ERST]) begin
            card_err_r <= 1'b0;
        end
    end
    // (R16) stuff request line, active low
    assign CARD_ERROR_STUFF_REQUEST_N = !card_err_r;

    // ======================================================================
    // Event history for interrupt edges
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            card_err_d_r <= 1'b0;
            active_d_r   <= 1'b0;
        end else begin
            card_err_d_r <= card_err_r;
            active_d_r   <= active;
        end
    end

    assign int_ev[`SBUF_INT_CARD_ERR] = card_err_r && !card_err_d_r;
    assign int_ev[`SBUF_INT_ACT_LOSS] = active_d_r && !active;
    assign int_ev[`SBUF_INT_MISMATCH] = mismatch;

    // ======================================================================
    // APB decode
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr    = PSEL && PENABLE && PWRITE;
    assign int_clr   = (apb_wr && PADDR == `SBUF_OFS_INT_STAT) ? PWDATA[2:0] : 3'h0;

    // Mapped offsets
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (PADDR)
            `SBUF_OFS_CTRL:     rd_mux = {30'h0, ctrl_r};
            `SBUF_OFS_FILL:     rd_mux = {22'h0, fill_r};
            `SBUF_OFS_STATUS: begin
                rd_mux[`SBUF_ST_WR_LSB +: AW]   = wr_addr_r;
                rd_mux[`SBUF_ST_RD_LSB +: AW]   = rd_addr_r;
                rd_mux[`SBUF_ST_CARD_ERR]       = card_err_r;
                rd_mux[`SBUF_ST_ACTIVE]         = active;
                rd_mux[`SBUF_ST_LEAD]           = lead_r;
                rd_mux[`SBUF_ST_LAG]            = lag_r;
                rd_mux[`SBUF_ST_WORD_LSB +: WW] = word_count;
                rd_mux[31]                      = rc_hold;
            end
            `SBUF_OFS_INT_STAT: rd_mux = {29'h0, int_stat_r};
            `SBUF_OFS_INT_MASK: rd_mux = {29'h0, int_mask_r};
            default:            mapped = 1'b0;
        endcase
    end

    // Answer registered in setup, presented in access
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (apb_setup) begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
            PSLVERR <= !mapped;
        end
    end
    assign PREADY = 1'b1;

    // Control registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_r     <= `SBUF_CTRL_RESET;
            fill_r     <= `SBUF_FILL_RESET;
            int_mask_r <= `SBUF_INT_RESET;
        end else if (apb_wr) begin
            if (PADDR == `SBUF_OFS_CTRL) begin
                ctrl_r <= PWDATA[1:0];
            end
            if (PADDR == `SBUF_OFS_FILL) begin
                fill_r <= PWDATA[WW-1:0];
            end
            if (PADDR == `SBUF_OFS_INT_MASK) begin
                int_mask_r <= PWDATA[2:0];
            end
        end
    end

    // ======================================================================
    // Sticky interrupt status, set wins over clear
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            int_stat_r <= `SBUF_INT_RESET;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
        end
    end

    assign IRQ = |(int_stat_r & int_mask_r);

endmodule

// ==== bench/sbuf_top_asserts.sv ====
// Port checker for the smoothing buffer.
// Assumes bind onto sbuf_top with its ACT_CYCLES.
`timescale 1ns/1ps
module sbuf_top_checker #(
    parameter int ACT_CYCLES = 2000
) (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic PREADY,
    input wire logic END_OF_SCAN_PULSE,
    input wire logic READ_CLOCK,
    input wire logic CHANNEL_DATA_OUT,
    input wire logic CHANNEL_DATA_OUT_N,
    input wire logic CHANNEL_TIMING_OUT,
    input wire logic CHANNEL_TIMING_OUT_N,
    input wire logic DATA_DRIVER_ERR,
    input wire logic TIMING_DRIVER_ERR,
    input wire logic ERROR_RESET,
    input wire logic SELF_TEST_FORCE,
    input wire logic CARD_ERROR_STUFF_REQUEST_N
);
    int idle_r; // Cycles since scan pin high
    int up_r;   // Cycles since reset release
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // ==========
    // Helper counters, both saturating
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            idle_r <= 0;
            up_r <= 0;
        end else begin
            idle_r <= END_OF_SCAN_PULSE ? 0 : (idle_r > ACT_CYCLES + 8 ? idle_r : idle_r + 1);
            up_r <= up_r > 2 ? up_r : up_r + 1;
        end
    end
    ready_high_a: assert property (PREADY) else $error("ready low");
    data_pair_a: assert property (!(CHANNEL_DATA_OUT && CHANNEL_DATA_OUT_N))
        else $error("data pair");
    time_pair_a: assert property (!(CHANNEL_TIMING_OUT && CHANNEL_TIMING_OUT_N))
        else $error("timing pair");
    timing_lag_a: assert property (up_r > 2 |-> CHANNEL_TIMING_OUT == $past(READ_CLOCK, 2))
        else $error("timing lag");
    scan_loss_a: assert property (idle_r > ACT_CYCLES + 6 |-> !CHANNEL_DATA_OUT)
        else $error("not inhibited");
    data_err_a: assert property ($rose(DATA_DRIVER_ERR) |-> ##[1:6] !CARD_ERROR_STUFF_REQUEST_N)
        else $error("data err lost");
    time_err_a: assert property ($rose(TIMING_DRIVER_ERR) |-> ##[1:6] !CARD_ERROR_STUFF_REQUEST_N)
        else $error("time err lost");
    self_test_a: assert property (SELF_TEST_FORCE [*5] |-> !CARD_ERROR_STUFF_REQUEST_N)
        else $error("self test");
    clear_only_a: assert property ($rose(CARD_ERROR_STUFF_REQUEST_N) |->
        $past(ERROR_RESET, 2) || $past(ERROR_RESET, 3) || $past(ERROR_RESET, 4))
        else $error("cleared unasked");
endmodule
bind sbuf_top sbuf_top_checker #(.ACT_CYCLES(ACT_CYCLES)) sbuf_top_checker_i (.*);

// ==== bench/sbuf_demux_model.sv ====
// Demultiplexer stand-in: gated clock, data, scan strobes, read clock.
// Assumes run is changed by the bench on its own clock.
`timescale 1ns/1ps
module sbuf_demux_model (
    input  wire logic run,
    output logic      gwc,
    output logic      din,
    output logic      eos,
    output logic      w24,
    output logic      w24b0,
    output logic      mf31,
    output logic      rclk
);
    int bitn; // Bit in word
    int word; // Word in frame
    bit go;   // Run taken as each bit starts
    // Eight bits a word, 400 ns a bit; clock still when idle
    initial begin
        {gwc, din, eos, w24, w24b0, mf31, rclk} = '0;
        bitn = 0;
        word = 0;
        forever begin
            go = run;
            din = go ? word[0] ^ bitn[1] : ~din;
            eos = go && bitn == 7;
            w24 = go && word == 24;
            w24b0 = go && word == 24 && bitn == 0;
            mf31 = go; // Frame 31 throughout
            #100 gwc = go;
            #200 gwc = 0;
            #100;
            if (go) begin
                bitn = (bitn + 1) % 8;
                word += (bitn == 0);
            end
        end
    end
    initial begin
        #37;
        forever #200 rclk = run & ~rclk;
    end
endmodule

// ==== bench/sbuf_top_tb.sv ====
// Bench for the smoothing buffer: APB tests plus demux stand-in.
// Assumes design, checker and partner model compiled first.
`timescale 1ns/1ps
module sbuf_top_tb;
    logic        clk, rst_b, psel, pen, pwr, run, rerr, qe;
    logic        pready, slverr, irq, card_n, gwc, din, eos, w24, w24b0, mf31, rclk;
    logic [2:0]  src;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          err_total, comparisons, cyc;
    sbuf_top #(.ACT_CYCLES(200)) sbuf_top_i (
        .CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(slverr),
        .IRQ(irq), .GATED_WRITE_CLOCK(gwc), .CHANNEL_DATA_IN(din), .END_OF_SCAN_PULSE(eos),
        .WORD24_STROBE(w24), .WORD24_BIT0_STROBE(w24b0), .MINOR_FRAME31(mf31),
        .READ_CLOCK(rclk), .PHASE_LEAD(), .PHASE_LAG(), .CHANNEL_DATA_OUT(),
        .CHANNEL_DATA_OUT_N(), .CHANNEL_TIMING_OUT(), .CHANNEL_TIMING_OUT_N(),
        .DATA_DRIVER_ERR(src[1]), .TIMING_DRIVER_ERR(src[2]), .ERROR_RESET(rerr),
        .SELF_TEST_FORCE(src[0]), .CARD_ERROR_STUFF_REQUEST_N(card_n));
    sbuf_demux_model sbuf_demux_model_i (.run(run), .gwc(gwc), .din(din), .eos(eos),
        .w24(w24), .w24b0(w24b0), .mf31(mf31), .rclk(rclk));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        qe = slverr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        {rst_b, psel, pen, pwr, run, rerr, src, paddr, pwdata} = '0;
        repeat (20) @(posedge clk);
        rst_b <= 1;
        for (int i = 0; i < 5; i++) begin
            apb(0, 12'(4 * i), 0);
            chk(q, i == 2 ? 32'h8 : 32'h0);
        end
        apb(0, 12'h014, 0);
        chk({q[30:0], qe}, 32'h1);
        apb(1, 12'h004, 32'hffffffff);
        apb(0, 12'h004, 0);
        chk(q, 32'h3ff);
        apb(1, 12'h004, 32'h200);
        apb(1, 12'h000, 32'h3);
        apb(1, 12'h010, 32'h7);
        apb(1, 12'h00c, 32'h7);
        $display("register test done");
        run <= 1;
        wait (sbuf_demux_model_i.word == 27);
        @(posedge clk);
        run <= 0;
        repeat (300) @(posedge clk);
        apb(0, 12'h008, 0);
        chk(q & 32'h83ff_030f, 32'h0002_0003);
        apb(0, 12'h00c, 0);
        chk({q[30:0], irq}, 32'h5);
        apb(1, 12'h00c, 32'h7);
        $display("stream test done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            chk(irq, 0);
            src <= 3'(1 << k);
            repeat (10) @(posedge clk);
            chk(card_n, 0);
            src <= 0;
            repeat (10) @(posedge clk);
            chk({irq, card_n}, 32'h2);
            rerr <= 1;
            repeat (10) @(posedge clk);
            rerr <= 0;
            chk(card_n, 1);
            apb(1, 12'h00c, 32'h7);
        end
        $display("error test done");
        print_verdict();
    end
endmodule
